// *** inc/swbs_pkg.sv ***
// Package for the status word and bank select block.
// Assumes one clock domain and a sequencer that issues one operation per cycle.
package swbs_pkg;

  localparam int DATA_ADDR_W = 12;
  localparam int NIBBLE_W = 4;
  localparam int BYTE_W = 8;

  // Data memory addresses of the status word halves
  localparam logic [11:0] PSW_LOW_ADDR = 12'hFB0;
  localparam logic [11:0] PSW_HIGH_ADDR = 12'hFB1;

  // Status word field positions
  localparam int POS_CARRY = 7;
  localparam int POS_SKIP_HIGH = 6;
  localparam int POS_SKIP_MID = 5;
  localparam int POS_SKIP_LOW = 4;
  localparam int POS_LEVEL_HIGH = 3;
  localparam int POS_LEVEL_LOW = 2;
  localparam int POS_MEM_EXPAND = 1;
  localparam int POS_REG_EXPAND = 0;

  // Expansion flag positions in a program memory word
  localparam int ROM_POS_MEM_EXPAND = 7;
  localparam int ROM_POS_REG_EXPAND = 6;

  // Reset values
  localparam logic [3:0] MEM_BANK_RESET = 4'h0;
  localparam logic [3:0] REG_BANK_RESET = 4'h0;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic CARRY_RESET = 1'b0;

  // Interrupt levels
  localparam logic [1:0] LEVEL_NORMAL = 2'h0;
  localparam logic [1:0] LEVEL_LOW_SVC = 2'h1;
  localparam logic [1:0] LEVEL_HIGH_SVC = 2'h2;
  localparam logic [1:0] LEVEL_BAD = 2'h3;

  // Legal memory and register bank values
  localparam logic [3:0] MEM_BANK_TOP = 4'hF;
  localparam logic [3:0] MEM_BANK_LAST_LOW = 4'h3;
  localparam logic [3:0] REG_BANK_LAST = 4'h3;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ADD_WITH_CARRY,
    OP_SUBTRACT_WITH_BORROW,
    OP_FORCE_CARRY_HIGH,
    OP_FORCE_CARRY_LOW,
    OP_INVERT_CARRY,
    OP_SKIP_WHEN_TRUE,
    OP_CARRY_TO_MEM,
    OP_MEM_TO_CARRY,
    OP_BIT_AND_WITH_CARRY,
    OP_BIT_OR_WITH_CARRY,
    OP_BIT_XOR_WITH_CARRY,
    OP_CHOOSE_MEMORY_BANK,
    OP_CHOOSE_REGISTER_BANK,
    OP_SAVE_BANK_WORD,
    OP_RESTORE_BANK_WORD,
    OP_CALL,
    OP_RETURN,
    OP_INTERRUPT_ENTRY,
    OP_INTERRUPT_RETURN
  } swbs_op_t;

endpackage : swbs_pkg

// *** core/swbs_bank_addr.sv ***
// Bank address generation from expansion flags and selectors.
// Assumes inputs come from registers of the same clock.
`timescale 1ns/1ps
`default_nettype none
module swbs_bank_addr (
  input wire logic clk,
  input wire logic nrst,
  input wire logic memExpand,
  input wire logic regExpand,
  input wire logic [3:0] memBankSel,
  input wire logic [3:0] regBankSel,
  output logic [3:0] dataBankHigh,
  output logic [1:0] activeRegBank
);
  import swbs_pkg::*;

  wire logic [3:0] bankHighNext;
  wire logic [1:0] regBankNext;

  assign bankHighNext = memExpand ? memBankSel : MEM_BANK_RESET;
  assign regBankNext = regExpand ? regBankSel[1:0] : 2'h0;

  // Registered so a change applies from the instruction after the following one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dataBankHigh <= MEM_BANK_RESET;
      activeRegBank <= 2'h0;
    end else begin
      dataBankHigh <= bankHighNext;
      activeRegBank <= regBankNext;
    end
  end

  property p_bank_delay;
    @(posedge clk) disable iff (!nrst)
      !memExpand ##1 !memExpand |-> dataBankHigh == MEM_BANK_RESET;
  endproperty
  a_bank_delay: assert property (p_bank_delay)
    else $error("bank used without expansion");

  property p_reg_bank_follow;
    @(posedge clk) disable iff (!nrst)
      regExpand |=> activeRegBank == $past(regBankSel[1:0]);
  endproperty
  a_reg_bank_follow: assert property (p_reg_bank_follow)
    else $error("register bank not applied next cycle");

endmodule : swbs_bank_addr
`default_nettype wire

// *** core/swbs_status_bank.sv ***
// Status word flags and bank selection of a 4-bit processor core.
// Assumes a sequencer on clk issues one operation per cycle with operands.
`timescale 1ns/1ps
`default_nettype none
module swbs_status_bank (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] romWordZero,
  input wire logic opValid,
  input wire swbs_pkg::swbs_op_t opCode,
  input wire logic [3:0] opBank,
  input wire logic [7:0] opByte,
  input wire logic aluCarry,
  input wire logic memBit,
  input wire logic [2:0] skipCond,
  input wire logic [11:0] memAddr,
  input wire logic memWrite,
  input wire logic [3:0] memWdata,
  output logic [3:0] memRdata,
  output logic memHit,
  output logic carryBit,
  output logic [7:0] statusWord,
  output logic [7:0] stackByte,
  output logic stackValid,
  output logic acceptLow,
  output logic acceptHigh,
  output logic [3:0] dataBankHigh,
  output logic [1:0] activeRegBank
);
  import swbs_pkg::*;

  logic carry_reg;
  logic [2:0] skip_reg;
  logic [1:0] level_reg;
  logic memExpand_reg;
  logic regExpand_reg;
  logic [3:0] memBank_reg;
  logic [3:0] regBank_reg;
  logic [7:0] stackByte_reg;
  logic stackValid_reg;
  logic [3:0] memRdata_reg;
  logic memHit_reg;
  logic acceptLow_reg;
  logic acceptHigh_reg;

  logic carry_next;
  logic [1:0] level_next;
  logic memExpand_next;
  logic regExpand_next;
  logic [3:0] memBank_next;
  logic [3:0] regBank_next;

  function automatic logic legalMemBank(input logic [3:0] b);
    legalMemBank = (b <= MEM_BANK_LAST_LOW) || (b == MEM_BANK_TOP);
  endfunction : legalMemBank

  function automatic logic [7:0] packStatus(input logic c,
      input logic [2:0] s, input logic [1:0] l, input logic me,
      input logic re);
    packStatus = {c, s, l, me, re};
  endfunction : packStatus

  wire logic [7:0] statusNow = packStatus(carry_reg, skip_reg, level_reg,
      memExpand_reg, regExpand_reg);
  wire logic isOp = opValid;
  wire logic lowWrite = memWrite && (memAddr == PSW_LOW_ADDR);
  wire logic anyHit = (memAddr == PSW_LOW_ADDR) ||
      (memAddr == PSW_HIGH_ADDR);
  wire logic levelWriteOk = memWdata[3:2] != LEVEL_BAD;
  wire logic sktHit = isOp && (opCode == OP_SKIP_WHEN_TRUE) && carry_reg;
  wire logic [1:0] levelRaised = level_reg + 2'h1;

  // Carry path
  always_comb begin
    carry_next = carry_reg;
    if (isOp) begin
      unique case (opCode)
        OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
          carry_next = aluCarry;
        end
        OP_FORCE_CARRY_HIGH: carry_next = 1'b1;
        OP_FORCE_CARRY_LOW: carry_next = 1'b0;
        OP_INVERT_CARRY: carry_next = !carry_reg;
        OP_MEM_TO_CARRY: carry_next = memBit;
        OP_BIT_AND_WITH_CARRY: carry_next = carry_reg & memBit;
        OP_BIT_OR_WITH_CARRY: carry_next = carry_reg | memBit;
        OP_BIT_XOR_WITH_CARRY: carry_next = carry_reg ^ memBit;
        OP_INTERRUPT_RETURN: carry_next = opByte[POS_CARRY];
        default: carry_next = carry_reg;
      endcase
    end
  end

  // Level and expansion flags
  always_comb begin
    level_next = level_reg;
    memExpand_next = memExpand_reg;
    regExpand_next = regExpand_reg;
    if (isOp && opCode == OP_INTERRUPT_ENTRY) begin
      level_next = (level_reg == LEVEL_HIGH_SVC) ? level_reg : levelRaised;
      memExpand_next = opByte[ROM_POS_MEM_EXPAND];
      regExpand_next = opByte[ROM_POS_REG_EXPAND];
    end else if (isOp && opCode == OP_INTERRUPT_RETURN) begin
      level_next = opByte[POS_LEVEL_HIGH:POS_LEVEL_LOW];
      memExpand_next = opByte[POS_MEM_EXPAND];
      regExpand_next = opByte[POS_REG_EXPAND];
    end else if (isOp && opCode == OP_RETURN) begin
      memExpand_next = opByte[POS_MEM_EXPAND];
      regExpand_next = opByte[POS_REG_EXPAND];
    end else if (lowWrite) begin
      if (levelWriteOk) begin
        level_next = memWdata[3:2];
      end
      memExpand_next = memWdata[POS_MEM_EXPAND];
      regExpand_next = memWdata[POS_REG_EXPAND];
    end
  end

  // Bank selectors
  always_comb begin
    memBank_next = memBank_reg;
    regBank_next = regBank_reg;
    if (isOp && opCode == OP_CHOOSE_MEMORY_BANK &&
        legalMemBank(opBank)) begin
      memBank_next = opBank;
    end
    if (isOp && opCode == OP_CHOOSE_REGISTER_BANK &&
        opBank <= REG_BANK_LAST) begin
      regBank_next = {2'h0, opBank[1:0]};
    end
    if (isOp && opCode == OP_RESTORE_BANK_WORD &&
        legalMemBank(opByte[3:0])) begin
      memBank_next = opByte[3:0];
      regBank_next = {2'h0, opByte[5:4]};
    end
  end

  // Reset values; carry is cleared although software may not rely on it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      carry_reg <= CARRY_RESET;
      level_reg <= LEVEL_RESET;
      memExpand_reg <= romWordZero[ROM_POS_MEM_EXPAND];
      regExpand_reg <= romWordZero[ROM_POS_REG_EXPAND];
      memBank_reg <= MEM_BANK_RESET;
      regBank_reg <= REG_BANK_RESET;
    end else begin
      carry_reg <= carry_next;
      level_reg <= level_next;
      memExpand_reg <= memExpand_next;
      regExpand_reg <= regExpand_next;
      memBank_reg <= memBank_next;
      regBank_reg <= regBank_next;
    end
  end

  // Skip flags follow execution only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      skip_reg <= 3'h0;
    end else if (isOp && opCode == OP_INTERRUPT_RETURN) begin
      skip_reg <= opByte[POS_SKIP_HIGH:POS_SKIP_LOW];
    end else if (isOp) begin
      skip_reg <= {skipCond[2:1], skipCond[0] | sktHit};
    end
  end

  // Stack byte for save operations
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stackByte_reg <= 8'h00;
      stackValid_reg <= 1'b0;
    end else begin
      stackValid_reg <= isOp && (opCode == OP_INTERRUPT_ENTRY ||
          opCode == OP_CALL || opCode == OP_SAVE_BANK_WORD ||
          opCode == OP_CARRY_TO_MEM);
      if (isOp && opCode == OP_INTERRUPT_ENTRY) begin
        stackByte_reg <= statusNow;
      end else if (isOp && opCode == OP_CALL) begin
        stackByte_reg <= {6'h00, memExpand_reg, regExpand_reg};
      end else if (isOp && opCode == OP_SAVE_BANK_WORD) begin
        stackByte_reg <= {regBank_reg, memBank_reg};
      end else if (isOp && opCode == OP_CARRY_TO_MEM) begin
        stackByte_reg <= {7'h00, carry_reg};
      end
    end
  end

  // Memory view; the high nibble reads zero and ignores writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      memRdata_reg <= 4'h0;
      memHit_reg <= 1'b0;
    end else begin
      memHit_reg <= anyHit;
      memRdata_reg <= (memAddr == PSW_LOW_ADDR) ? statusNow[3:0] :
          4'h0;
    end
  end

  // Acceptance follows the level being entered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acceptLow_reg <= 1'b1;
      acceptHigh_reg <= 1'b1;
    end else begin
      acceptLow_reg <= level_next == LEVEL_NORMAL;
      acceptHigh_reg <= level_next == LEVEL_NORMAL ||
          level_next == LEVEL_LOW_SVC;
    end
  end

  swbs_bank_addr u_bank_addr (
    .clk(clk),
    .nrst(nrst),
    .memExpand(memExpand_reg),
    .regExpand(regExpand_reg),
    .memBankSel(memBank_reg),
    .regBankSel(regBank_reg),
    .dataBankHigh(dataBankHigh),
    .activeRegBank(activeRegBank)
  );

  assign memRdata = memRdata_reg;
  assign memHit = memHit_reg;
  assign carryBit = carry_reg;
  assign statusWord = statusNow;
  assign stackByte = stackByte_reg;
  assign stackValid = stackValid_reg;
  assign acceptLow = acceptLow_reg;
  assign acceptHigh = acceptHigh_reg;

  property p_carry_add;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_ADD_WITH_CARRY |=> carryBit == $past(aluCarry);
  endproperty
  a_carry_add: assert property (p_carry_add)
    else $error("carry not taken from adder");

  property p_carry_xor;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_BIT_XOR_WITH_CARRY |=>
        carryBit == ($past(carryBit) ^ $past(memBit));
  endproperty
  a_carry_xor: assert property (p_carry_xor)
    else $error("xor with carry wrong");

  property p_invert_only_carry;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_INVERT_CARRY && !lowWrite |=>
        carryBit != $past(carryBit) &&
        statusWord[3:0] == $past(statusWord[3:0]);
  endproperty
  a_invert_only_carry: assert property (p_invert_only_carry)
    else $error("invert touched more than carry");

  property p_level_raise;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_INTERRUPT_ENTRY && level_reg == LEVEL_NORMAL
      |=> level_reg == LEVEL_LOW_SVC && stackByte == $past(statusNow);
  endproperty
  a_level_raise: assert property (p_level_raise)
    else $error("level not raised by one");

  property p_never_bad_level;
    @(posedge clk) disable iff (!nrst)
      lowWrite && memWdata[3:2] == LEVEL_BAD |=> level_reg != LEVEL_BAD;
  endproperty
  a_never_bad_level: assert property (p_never_bad_level)
    else $error("prohibited level stored");

  property p_accept_gate;
    @(posedge clk) disable iff (!nrst)
      level_reg == LEVEL_HIGH_SVC ##1 level_reg == LEVEL_HIGH_SVC |->
        !acceptLow && !acceptHigh;
  endproperty
  a_accept_gate: assert property (p_accept_gate)
    else $error("accept while in high service");

  property p_mem_bank_legal;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_CHOOSE_MEMORY_BANK && !legalMemBank(opBank)
      |=> $stable(memBank_reg);
  endproperty
  a_mem_bank_legal: assert property (p_mem_bank_legal)
    else $error("illegal memory bank accepted");

  property p_reg_bank_upper;
    @(posedge clk) disable iff (!nrst)
      regBank_reg[3:2] == 2'h0;
  endproperty
  a_reg_bank_upper: assert property (p_reg_bank_upper)
    else $error("register bank upper bits set");

  property p_call_save;
    @(posedge clk) disable iff (!nrst)
      opValid && opCode == OP_CALL |=>
        stackValid && stackByte[7:2] == 6'h00;
  endproperty
  a_call_save: assert property (p_call_save)
    else $error("call saved more than expand flags");

endmodule : swbs_status_bank
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the status word and bank select block.
// Assumes swbs_pkg is compiled first; the bench drives every input itself.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swbs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] romWordZero = 8'h80;
  logic opValid = 1'b0;
  swbs_op_t opCode = OP_NONE;
  logic [3:0] opBank = 4'h0;
  logic [7:0] opByte = 8'h00;
  logic aluCarry = 1'b0;
  logic memBit = 1'b0;
  logic [2:0] skipCond = 3'h0;
  logic [11:0] memAddr = 12'h000;
  logic memWrite = 1'b0;
  logic [3:0] memWdata = 4'h0;
  logic [3:0] memRdata;
  logic memHit;
  logic carryBit;
  logic [7:0] statusWord;
  logic [7:0] stackByte;
  logic stackValid;
  logic acceptLow;
  logic acceptHigh;
  logic [3:0] dataBankHigh;
  logic [1:0] activeRegBank;
  int mismatches = 0;
  int num_checks = 0;
  logic [15:0] lfsr = 16'hA7D0;
  // Expected state
  logic eCy;
  logic [2:0] eSk;
  logic [1:0] eLv;
  logic eMe;
  logic eRe;
  logic [3:0] eMb;
  logic [3:0] eRb;
  swbs_op_t carryOps [11] = '{OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW,
    OP_FORCE_CARRY_HIGH, OP_FORCE_CARRY_LOW, OP_INVERT_CARRY,
    OP_SKIP_WHEN_TRUE, OP_CARRY_TO_MEM, OP_MEM_TO_CARRY,
    OP_BIT_AND_WITH_CARRY, OP_BIT_OR_WITH_CARRY, OP_BIT_XOR_WITH_CARRY};

  always #2.5 clk = ~clk;

  swbs_status_bank u_swbs_status_bank (
    .clk(clk),
    .nrst(nrst),
    .romWordZero(romWordZero),
    .opValid(opValid),
    .opCode(opCode),
    .opBank(opBank),
    .opByte(opByte),
    .aluCarry(aluCarry),
    .memBit(memBit),
    .skipCond(skipCond),
    .memAddr(memAddr),
    .memWrite(memWrite),
    .memWdata(memWdata),
    .memRdata(memRdata),
    .memHit(memHit),
    .carryBit(carryBit),
    .statusWord(statusWord),
    .stackByte(stackByte),
    .stackValid(stackValid),
    .acceptLow(acceptLow),
    .acceptHigh(acceptHigh),
    .dataBankHigh(dataBankHigh),
    .activeRegBank(activeRegBank)
  );

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd

  function automatic logic [7:0] expWord();
    return {eCy, eSk, eLv, eMe, eRe};
  endfunction : expWord

  function automatic logic [7:0] bankExp();
    return {2'b00, eRe ? eRb[1:0] : 2'b00, eMe ? eMb : 4'h0};
  endfunction : bankExp

  function automatic logic [7:0] bankOut();
    return {2'b00, activeRegBank, dataBankHigh};
  endfunction : bankOut

  function automatic logic memLegal(input logic [3:0] b);
    return b <= MEM_BANK_LAST_LOW || b == MEM_BANK_TOP;
  endfunction : memLegal

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic doReset(input logic [7:0] rw);
    @(posedge clk);
    nrst <= 1'b0;
    romWordZero <= rw;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    {eCy, eSk, eLv, eMb, eRb} = '0;
    {eMe, eRe} = rw[7:6];
    #1;
    chk8(statusWord, expWord());
    chk1(stackValid, 1'b0);
    chk1(acceptLow & acceptHigh, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk8(bankOut(), bankExp());
  endtask : doReset

  task automatic doOp(input swbs_op_t op, input logic [3:0] b,
                      input logic [7:0] by);
    logic [7:0] r;
    logic [7:0] old;
    logic [7:0] ob;
    logic [7:0] stk;
    logic sv;
    r = rnd();
    old = expWord();
    ob = bankExp();
    stk = 8'h00;
    sv = 1'b0;
    @(posedge clk);
    opValid <= 1'b1;
    opCode <= op;
    opBank <= b;
    opByte <= by;
    aluCarry <= r[0];
    memBit <= r[1];
    skipCond <= (op == OP_INTERRUPT_RETURN) ? by[6:4] : r[4:2];
    @(posedge clk);
    opValid <= 1'b0;
    eSk = r[4:2];
    case (op)
      OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: eCy = r[0];
      OP_FORCE_CARRY_HIGH: eCy = 1'b1;
      OP_FORCE_CARRY_LOW: eCy = 1'b0;
      OP_INVERT_CARRY: eCy = ~eCy;
      OP_SKIP_WHEN_TRUE: eSk[0] = eSk[0] | eCy;
      OP_CARRY_TO_MEM: {sv, stk} = {1'b1, 7'h00, eCy};
      OP_MEM_TO_CARRY: eCy = r[1];
      OP_BIT_AND_WITH_CARRY: eCy = eCy & r[1];
      OP_BIT_OR_WITH_CARRY: eCy = eCy | r[1];
      OP_BIT_XOR_WITH_CARRY: eCy = eCy ^ r[1];
      OP_CHOOSE_MEMORY_BANK: if (memLegal(b)) eMb = b;
      OP_CHOOSE_REGISTER_BANK: if (b <= REG_BANK_LAST) eRb = b;
      OP_SAVE_BANK_WORD: {sv, stk} = {1'b1, eRb, eMb};
      OP_RESTORE_BANK_WORD: if (memLegal(by[3:0])) {eRb, eMb} = by;
      OP_CALL: {sv, stk} = {1'b1, 6'h00, eMe, eRe};
      OP_RETURN: {eMe, eRe} = by[1:0];
      OP_INTERRUPT_ENTRY: begin
        {sv, stk} = {1'b1, old};
        if (eLv != LEVEL_HIGH_SVC) eLv = eLv + 2'h1;
        {eMe, eRe} = by[7:6];
      end
      OP_INTERRUPT_RETURN: {eCy, eSk, eLv, eMe, eRe} = by;
      default: ;
    endcase
    #1;
    chk1(stackValid, sv);
    if (sv) chk8(stackByte, stk);
    chk8(statusWord, expWord());
    chk1(carryBit, eCy);
    chk1(acceptLow, eLv == LEVEL_NORMAL);
    chk1(acceptHigh, eLv != LEVEL_HIGH_SVC);
    chk8(bankOut(), ob);
    @(posedge clk);
    #1;
    chk8(bankOut(), bankExp());
  endtask : doOp

  task automatic memAcc(input logic [11:0] a, input logic we,
                        input logic [3:0] wd);
    logic [3:0] nib;
    nib = (a == PSW_LOW_ADDR) ? {eLv, eMe, eRe} : 4'h0;
    @(posedge clk);
    memAddr <= a;
    memWrite <= we;
    memWdata <= wd;
    @(posedge clk);
    memWrite <= 1'b0;
    if (we && a == PSW_LOW_ADDR) begin
      if (wd[3:2] != LEVEL_BAD) eLv = wd[3:2];
      {eMe, eRe} = wd[1:0];
    end
    #1;
    chk8({4'h0, memRdata}, {4'h0, nib});
    chk1(memHit, a == PSW_LOW_ADDR || a == PSW_HIGH_ADDR);
    chk8(statusWord, expWord());
    @(posedge clk);
    #1;
    chk8(bankOut(), bankExp());
  endtask : memAcc

  initial begin
    swbs_op_t opc;
    logic [7:0] by;
    doReset(8'h80);
    for (int b = 0; b < 16; b++)
      doOp(OP_CHOOSE_MEMORY_BANK, 4'(b), 8'h00);
    for (int b = 0; b < 8; b++)
      doOp(OP_CHOOSE_REGISTER_BANK, 4'(b), 8'h00);
    memAcc(PSW_LOW_ADDR, 1'b1, 4'h3);
    for (int b = 7; b >= 0; b--)
      doOp(OP_CHOOSE_REGISTER_BANK, 4'(b), 8'h00);
    doOp(OP_SAVE_BANK_WORD, 4'h0, 8'h00);
    doOp(OP_RESTORE_BANK_WORD, 4'h0, 8'h25);
    doOp(OP_RESTORE_BANK_WORD, 4'h0, 8'h2F);
    doOp(OP_SAVE_BANK_WORD, 4'h0, 8'h00);
    for (int i = 0; i < 4; i++)
      doOp(OP_INTERRUPT_ENTRY, 4'h0, rnd());
    doOp(OP_INTERRUPT_ENTRY, 4'h0, 8'h00);
    doOp(OP_INTERRUPT_RETURN, 4'h0, 8'hA6);
    doOp(OP_CALL, 4'h0, 8'h00);
    doOp(OP_RETURN, 4'h0, 8'hFE);
    memAcc(PSW_LOW_ADDR, 1'b1, 4'hE);
    memAcc(PSW_HIGH_ADDR, 1'b1, 4'h0);
    memAcc(12'h123, 1'b1, 4'h5);
    for (int i = 0; i < 44; i++)
      doOp(carryOps[i % 11], 4'h0, 8'h00);
    doReset(8'h40);
    for (int i = 0; i < 80; i++) begin
      opc = swbs_op_t'(5'(rnd() % 8'd20));
      by = rnd();
      by[3] = by[3] & ~by[2];
      if (opc == OP_RESTORE_BANK_WORD) by[7:6] = 2'b00;
      doOp(opc, 4'(rnd()), by);
      if (by[0]) memAcc(PSW_LOW_ADDR, by[1], 4'(rnd()));
    end
    results();
  end

  initial begin
    #50000;
    mismatches++;
    results();
  end
endmodule : tb_top
`default_nettype wire
